/* File: bench/lsl_ctrl_model.sv */
// Display controller model driving the serial link pins
`timescale 1ns/1ps
module lsl_ctrl_model (
  input wire logic aclk, // pacing clock
  input wire logic serial_out, // data back
  output logic shift_clk, // link clock, still between frames
  output logic serial_in, // data out
  output logic latch_strobe, // latch pin
  output logic blank // blanking pin
);
  initial
  begin
    shift_clk = 1'b0;
    serial_in = 1'b0;
    latch_strobe = 1'b0;
    blank = 1'b1;
  end

  // Four aclk cycles each half gives the 400 ns link period
  task automatic frame(input logic [15:0] w, output logic [15:0] rx);
    for (int i = 15; i >= 0; i--)
    begin
      @(posedge aclk);
      shift_clk <= 1'b0;
      serial_in <= w[i];
      repeat (4) @(posedge aclk);
      rx = {rx[14:0], serial_out};
      shift_clk <= 1'b1;
      repeat (3) @(posedge aclk);
    end
    @(posedge aclk);
    shift_clk <= 1'b0;
    // Released line shows the inverse so a stale bit cannot pass
    serial_in <= ~w[0];
    repeat (4) @(posedge aclk);
    latch_strobe <= 1'b1;
    repeat (4) @(posedge aclk);
    latch_strobe <= 1'b0;
    repeat (8) @(posedge aclk);
  endtask : frame

  task automatic set_blank(input logic b);
    @(posedge aclk);
    blank <= b;
  endtask : set_blank
endmodule : lsl_ctrl_model

/* File: bench/lsl_props.sv */
// Port-level checks for the LED shift latch top module
`timescale 1ns/1ps
module lsl_props #(
  parameter int N = 16
) (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic shift_clk, // link clock
  input wire logic latch_strobe, // latch pin
  input wire logic blank, // blanking pin
  input wire logic serial_out, // serial out
  input wire logic [N-1:0] sink_output, // sinks
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready // r ready
);
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  AST_BLANK_OFF: assert property (blank [*5] |-> sink_output == '0)
    else $error("sink on while blanked");
  // Overtemp may toggle inside the window: it must never move a sink
  AST_SINK_STABLE: assert property (
    (!latch_strobe && !s_axi_awvalid && $stable(blank)) [*8] |=> $stable(sink_output))
    else $error("sink moved without cause");
  AST_SERIAL_OUT_CAUSE: assert property (
    !$stable(serial_out) |-> $past(shift_clk, 2) || $past(latch_strobe, 2))
    else $error("serial out moved without link edge");
  AST_B_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped early");
  AST_R_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped early");
  AST_R_LAT: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  AST_B_LAT: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:3] s_axi_bvalid)
    else $error("write answer late");
  AST_AR_BUSY: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken while answer pending");
endmodule : lsl_props

/* File: bench/test_led_onoff_shift_latch_status.sv */
// Self-checking bench for the LED shift latch with status read-back
`timescale 1ns/1ps
module test_led_onoff_shift_latch_status;
  logic aclk, aresetn, shift_clk, serial_in, latch_strobe, blank, serial_out;
  logic overtemp_ind, irq, ot;
  logic [15:0] sink_output, low_volt_det, w, lv, rx;
  logic [15:0] hist [0:7];
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, r;
  int err_count, checks_done, seed;

  always #25 aclk = ~aclk;

  lsl_top dut (.aclk, .aresetn, .shift_clk, .serial_in, .latch_strobe, .blank, .serial_out,
    .sink_output, .low_volt_det, .overtemp_ind, .irq,
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));

  lsl_ctrl_model ctl (.aclk, .serial_out, .shift_clk, .serial_in, .latch_strobe, .blank);

  function automatic logic [15:0] exp_stat(input logic [15:0] on, input logic [15:0] det,
    input logic hot);
    exp_stat = hot ? 16'hFFFF : (on & det);
  endfunction : exp_stat

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      err_count++;
    end
  endtask : chk

  task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] resp);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1)
      begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1)
      begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    // Ready comes a cycle late so the slave must hold its answer
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] resp);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    v = rdata;
    resp = rresp;
    rready <= 1'b0;
  endtask : axi_rd

  task automatic conclude();
    $display("checks=%0d mismatches=%0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : conclude

  initial
  begin
    repeat (20000) @(posedge aclk);
    err_count++;
    conclude();
  end

  initial
  begin
    seed = 32'h741F6067;
    {aclk, aresetn, overtemp_ind, low_volt_det, awaddr, araddr, wdata} = '0;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    wstrb = 4'hF;
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (3) @(posedge aclk);
    axi_rd(lsl_pkg::OFS_CTRL, d, r);
    chk(d, 32'h0);
    axi_rd(8'h40, d, r);
    chk({30'h0, r}, {30'h0, lsl_pkg::RESP_SLVERR});
    axi_wr(8'h44, 32'h1, r);
    chk({30'h0, r}, {30'h0, lsl_pkg::RESP_SLVERR});
    for (int it = 0; it < 6; it++)
    begin
      w = 16'($random(seed));
      if (it == 0) w[15] = 1'b0;
      lv = 16'($random(seed));
      ot = (it == 1) || (it > 2 && ($random(seed) & 3) == 0);
      ctl.frame(w, rx);
      if (it >= 2) chk({16'h0, rx}, {16'h0, hist[it-2]});
      chk({16'h0, sink_output}, 32'h0);
      axi_rd(lsl_pkg::OFS_ONOFF, d, r);
      chk(d, {16'h0, w});
      if (it == 0)
      begin
        axi_rd(lsl_pkg::OFS_IRQ_STAT, d, r);
        chk(d, 32'h1);
        chk({31'h0, irq}, 32'h0);
        axi_wr(lsl_pkg::OFS_IRQ_MASK, 32'h7, r);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h1);
        axi_wr(lsl_pkg::OFS_IRQ_STAT, 32'h1, r);
        repeat (3) @(posedge aclk);
        chk({31'h0, irq}, 32'h0);
      end
      low_volt_det <= lv;
      overtemp_ind <= ot;
      ctl.set_blank(1'b0);
      repeat (30) @(posedge aclk);
      chk({16'h0, sink_output}, {16'h0, w});
      if (it == 0)
      begin
        axi_wr(lsl_pkg::OFS_CTRL, 32'h1, r);
        repeat (4) @(posedge aclk);
        chk({16'h0, sink_output}, 32'h0);
        axi_wr(lsl_pkg::OFS_CTRL, 32'h0, r);
        repeat (30) @(posedge aclk);
      end
      ctl.set_blank(1'b1);
      repeat (10) @(posedge aclk);
      chk({16'h0, sink_output}, 32'h0);
      hist[it] = exp_stat(w, lv, ot);
      axi_rd(lsl_pkg::OFS_STATUS, d, r);
      chk(d, {14'h0, 1'b1, ot, hist[it]});
      if (it == 0) chk({31'h0, irq}, 32'h1);
      axi_wr(lsl_pkg::OFS_IRQ_STAT, 32'h7, r);
      // Inputs move while blanked so a capture that is not held shows up later
      low_volt_det <= ~lv;
      overtemp_ind <= ~ot;
    end
    conclude();
  end
endmodule : test_led_onoff_shift_latch_status

bind lsl_top lsl_props #(.N(N)) u_props (.aclk, .aresetn, .shift_clk, .latch_strobe, .blank,
  .serial_out, .sink_output, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

/* File: verilog/lsl_pkg.sv */
// Constants, register map and decode helpers for the LED on/off shift latch block
// Behaviour
// - Blanking low: each sink follows its on/off latch bit, one on, zero off; the software force-off bit also holds them off.
// - Blanking high forces all sixteen sinks off regardless of latch contents.
// - Shift register and on/off latch have no reset value; contents arbitrary until written.
// - Shift register and on/off latch are sixteen bits, one per sink.
// - Each shift clock rise shifts serial input into bit zero; serial output updates too.
// - Latch strobe rise copies shift register to latch and loads status word.
// - Blanking low: open-LED flag is one when channel on and low voltage seen.
// - Overtemp bit is one while overtemp seen; else status follows open-LED flags.
// - Overtemp never turns any sink off.
// - Status captured at blanking rise and held until blanking goes low; the code holds it until the next blanking rise.
// - Loaded status word shifts out bit by bit on shift clock rises.
// - Captured overtemp forces every open-LED status bit to one.
package lsl_pkg;

  localparam int N_CH = 16;
  localparam int ADDR_W = 8;

  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_ONOFF = 8'h04;
  localparam logic [7:0] OFS_STATUS = 8'h08;
  localparam logic [7:0] OFS_LIVE = 8'h0C;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h10;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h14;

  localparam int CTRL_FORCE_OFF = 0;
  localparam int STAT_PTW_BIT = 16;
  localparam int STAT_ONTIME_BIT = 17;
  localparam int LIVE_BLANK_BIT = 16;
  localparam int LIVE_PTW_BIT = 17;

  localparam int IRQ_W = 3;
  localparam int IRQ_LATCH = 0;
  localparam int IRQ_CAPTURE = 1;
  localparam int IRQ_PTW = 2;

  localparam logic CTRL_RESET = 1'b0;
  localparam logic [2:0] IRQ_MASK_RESET = 3'h0;
  localparam logic [15:0] STATUS_RESET = 16'h0000;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  localparam int CLK_MHZ = 20;
  localparam int ON_TIME_NS = 1000;
  localparam int ON_TIME_CYC = (ON_TIME_NS * CLK_MHZ + 999) / 1000;

  function automatic logic reg_known(input logic [7:0] addr);
    reg_known = (addr == OFS_CTRL) || (addr == OFS_ONOFF) || (addr == OFS_STATUS) ||
                (addr == OFS_LIVE) || (addr == OFS_IRQ_STAT) || (addr == OFS_IRQ_MASK);
  endfunction : reg_known

endpackage : lsl_pkg

/* File: verilog/lsl_stat_if.sv */
// Carrier between the core and the status capture unit
`timescale 1ns/1ps
interface lsl_stat_if;
  logic blank;
  logic blank_rise;
  logic overtemp;
  logic [15:0] low_volt;
  logic [15:0] onoff;
  logic [15:0] status_word;
  logic ptw_cap;
  logic ontime_ok;
  logic captured;

  modport cap
  (
    input blank, blank_rise, overtemp, low_volt, onoff,
    output status_word, ptw_cap, ontime_ok, captured
  );
  modport core
  (
    output blank, blank_rise, overtemp, low_volt, onoff,
    input status_word, ptw_cap, ontime_ok, captured
  );
endinterface : lsl_stat_if

/* File: verilog/lsl_status_cap.sv */
// Open-LED and overtemperature detection with status capture on blanking rise
`timescale 1ns/1ps
module lsl_status_cap (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  lsl_stat_if.cap st // Status carrier
);
  logic [15:0] open_q;
  logic ptw_q;
  logic [15:0] status_q;
  logic ptw_cap_q;
  logic ontime_ok_q;
  logic captured_q;
  logic [$clog2(lsl_pkg::ON_TIME_CYC+1)-1:0] on_cnt_q;

  // Flags are tracked while blanking is low so the value just before the rise is kept
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      open_q <= lsl_pkg::STATUS_RESET;
      ptw_q <= 1'b0;
    end
    else if (!st.blank)
    begin
      open_q <= st.onoff & st.low_volt;
      ptw_q <= st.overtemp;
    end
  end

  // Counts on-time so software can see whether the open-LED flags had time to settle
  always_ff @(posedge aclk)
  begin
    if (!aresetn || st.blank)
      on_cnt_q <= '0;
    else if (on_cnt_q != lsl_pkg::ON_TIME_CYC[$bits(on_cnt_q)-1:0])
      on_cnt_q <= on_cnt_q + 1'b1;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      status_q <= lsl_pkg::STATUS_RESET;
      ptw_cap_q <= 1'b0;
      ontime_ok_q <= 1'b0;
      captured_q <= 1'b0;
    end
    else
    begin
      captured_q <= st.blank_rise;
      if (st.blank_rise)
      begin
        status_q <= ptw_q ? {16{1'b1}} : open_q;
        ptw_cap_q <= ptw_q;
        ontime_ok_q <= (on_cnt_q == lsl_pkg::ON_TIME_CYC[$bits(on_cnt_q)-1:0]);
      end
    end
  end

  assign st.status_word = status_q;
  assign st.ptw_cap = ptw_cap_q;
  assign st.ontime_ok = ontime_ok_q;
  assign st.captured = captured_q;
endmodule : lsl_status_cap

/* File: verilog/lsl_sync.sv */
// Two-stage synchroniser with rising-edge detect for pin inputs
`timescale 1ns/1ps
module lsl_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic aclk, // System clock
  input wire logic aresetn, // Synchronous reset, active low
  input wire logic [W-1:0] pin, // Asynchronous inputs
  output logic [W-1:0] level, // Synchronised level
  output logic [W-1:0] rise // One-cycle pulse on rising edge
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // Edge detect looks only at stages two and three, never at the metastable first stage
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s1_q <= INIT;
      s2_q <= INIT;
      s3_q <= INIT;
    end
    else
    begin
      s1_q <= pin;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign level = s2_q;
  assign rise = s2_q & ~s3_q;
endmodule : lsl_sync

/* File: verilog/lsl_top.sv */
// LED sink on/off shift register, latch and status read-back with AXI4-Lite registers
`timescale 1ns/1ps
module lsl_top #(
  parameter int N = lsl_pkg::N_CH
) (
  input wire logic aclk, // System clock, 20 MHz
  input wire logic aresetn, // Synchronous reset, active low
  // Serial link pins, asynchronous to aclk
  input wire logic shift_clk, // Link shift clock
  input wire logic serial_in, // Serial data in
  input wire logic latch_strobe, // Latch strobe, rising edge acts
  input wire logic blank, // Blanking, high forces all sinks off
  output logic serial_out, // Serial data out
  // Sink and sensing
  output logic [N-1:0] sink_output, // Sink on, high per channel
  input wire logic [N-1:0] low_volt_det, // Per-channel low output voltage indication
  input wire logic overtemp_ind, // Overtemperature indication
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr, // Write address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write strobes
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [7:0] s_axi_araddr, // Read address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  output logic irq // Interrupt, high while an unmasked event is pending
);

  lsl_stat_if st ();

  logic sclk_lvl;
  logic sclk_rise;
  logic sin_lvl;
  logic lat_lvl;
  logic lat_rise;
  logic blank_lvl;
  logic blank_rise;
  logic ptw_lvl;
  logic [N-1:0] lvd_lvl;

  // Blanking synchroniser starts high so sinks stay off through reset
  lsl_sync #(.W(1), .INIT(1'b1)) u_sync_blank (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(blank),
    .level(blank_lvl),
    .rise(blank_rise)
  );

  lsl_sync #(.W(1), .INIT(1'b0)) u_sync_sclk (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(shift_clk),
    .level(sclk_lvl),
    .rise(sclk_rise)
  );

  lsl_sync #(.W(1), .INIT(1'b0)) u_sync_lat (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(latch_strobe),
    .level(lat_lvl),
    .rise(lat_rise)
  );

  // Data and clock go through equal-depth synchronisers, so the sampled bit keeps its setup
  lsl_sync #(.W(1), .INIT(1'b0)) u_sync_sin (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(serial_in),
    .level(sin_lvl),
    .rise()
  );

  lsl_sync #(.W(1), .INIT(1'b0)) u_sync_ptw (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(overtemp_ind),
    .level(ptw_lvl),
    .rise()
  );

  lsl_sync #(.W(N), .INIT('0)) u_sync_lvd (
    .aclk(aclk),
    .aresetn(aresetn),
    .pin(low_volt_det),
    .level(lvd_lvl),
    .rise()
  );

  // Shift register and on/off latch

  logic [N-1:0] shift_q;
  logic [N-1:0] onoff_q;
  logic serial_out_q;

  // No reset on purpose: contents are undefined until the controller writes them
  always_ff @(posedge aclk)
  begin
    if (lat_rise)
      shift_q <= st.status_word;
    else if (sclk_rise)
      shift_q <= {shift_q[N-2:0], sin_lvl};
  end

  always_ff @(posedge aclk)
  begin
    if (lat_rise)
      onoff_q <= shift_q;
  end

  // Serial output tracks the shift register's top bit; reset only keeps the pin defined
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      serial_out_q <= 1'b0;
    else if (lat_rise)
      serial_out_q <= st.status_word[N-1];
    else if (sclk_rise)
      serial_out_q <= shift_q[N-2];
  end

  assign serial_out = serial_out_q;

  // Control register

  logic ctrl_force_off_q;

  // Overtemp has no path here: only blanking or the software override turn sinks off
  logic [N-1:0] sink_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      sink_q <= '0;
    else if (blank_lvl || ctrl_force_off_q)
      sink_q <= '0;
    else
      sink_q <= onoff_q;
  end

  assign sink_output = sink_q;

  // Status capture unit

  assign st.blank = blank_lvl;
  assign st.blank_rise = blank_rise;
  assign st.overtemp = ptw_lvl;
  assign st.low_volt = lvd_lvl;
  assign st.onoff = sink_q;

  lsl_status_cap u_cap (
    .aclk(aclk),
    .aresetn(aresetn),
    .st(st.cap)
  );

  // AXI4-Lite write path: address and data are taken independently

  logic aw_full_q;
  logic w_full_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  logic wr_fire;

  assign s_axi_awready = !aw_full_q && !bvalid_q;
  assign s_axi_wready = !w_full_q && !bvalid_q;
  assign wr_fire = aw_full_q && w_full_q && !bvalid_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_full_q <= 1'b0;
      aw_addr_q <= 8'h00;
    end
    else if (s_axi_awvalid && s_axi_awready)
    begin
      aw_full_q <= 1'b1;
      aw_addr_q <= s_axi_awaddr;
    end
    else if (wr_fire)
      aw_full_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      w_full_q <= 1'b0;
      w_data_q <= 32'h00000000;
      w_strb_q <= 4'h0;
    end
    else if (s_axi_wvalid && s_axi_wready)
    begin
      w_full_q <= 1'b1;
      w_data_q <= s_axi_wdata;
      w_strb_q <= s_axi_wstrb;
    end
    else if (wr_fire)
      w_full_q <= 1'b0;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      bvalid_q <= 1'b0;
      bresp_q <= lsl_pkg::RESP_OKAY;
    end
    else if (wr_fire)
    begin
      bvalid_q <= 1'b1;
      bresp_q <= lsl_pkg::reg_known(aw_addr_q) ? lsl_pkg::RESP_OKAY : lsl_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      bvalid_q <= 1'b0;
  end

  assign s_axi_bvalid = bvalid_q;
  assign s_axi_bresp = bresp_q;

  logic wr_ctrl;
  logic wr_irq_stat;
  logic wr_irq_mask;

  // Only byte lane 0 carries writable bits
  assign wr_ctrl = wr_fire && (aw_addr_q == lsl_pkg::OFS_CTRL) && w_strb_q[0];
  assign wr_irq_stat = wr_fire && (aw_addr_q == lsl_pkg::OFS_IRQ_STAT) && w_strb_q[0];
  assign wr_irq_mask = wr_fire && (aw_addr_q == lsl_pkg::OFS_IRQ_MASK) && w_strb_q[0];

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      ctrl_force_off_q <= lsl_pkg::CTRL_RESET;
    else if (wr_ctrl)
      ctrl_force_off_q <= w_data_q[lsl_pkg::CTRL_FORCE_OFF];
  end

  // Interrupt status and mask

  logic [lsl_pkg::IRQ_W-1:0] irq_stat_q;
  logic [lsl_pkg::IRQ_W-1:0] irq_mask_q;
  logic [lsl_pkg::IRQ_W-1:0] irq_evt;
  logic [lsl_pkg::IRQ_W-1:0] irq_clr;

  assign irq_evt[lsl_pkg::IRQ_LATCH] = lat_rise;
  assign irq_evt[lsl_pkg::IRQ_CAPTURE] = st.captured;
  assign irq_evt[lsl_pkg::IRQ_PTW] = st.captured && st.ptw_cap;
  assign irq_clr = wr_irq_stat ? w_data_q[lsl_pkg::IRQ_W-1:0] : '0;

  // A new event in the clearing cycle survives the write-one-to-clear
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_stat_q <= '0;
    else
      irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_evt;
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq_mask_q <= lsl_pkg::IRQ_MASK_RESET;
    else if (wr_irq_mask)
      irq_mask_q <= w_data_q[lsl_pkg::IRQ_W-1:0];
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      irq <= 1'b0;
    else
      irq <= |(irq_stat_q & irq_mask_q);
  end

  // AXI4-Lite read path: one read outstanding, answer one cycle after acceptance

  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  logic [31:0] rd_mux;

  assign s_axi_arready = !rvalid_q;

  always_comb
  begin
    rd_mux = 32'h00000000;
    case (s_axi_araddr)
      lsl_pkg::OFS_CTRL:
        rd_mux[lsl_pkg::CTRL_FORCE_OFF] = ctrl_force_off_q;
      lsl_pkg::OFS_ONOFF:
        rd_mux[N-1:0] = onoff_q;
      lsl_pkg::OFS_STATUS:
      begin
        rd_mux[N-1:0] = st.status_word;
        rd_mux[lsl_pkg::STAT_PTW_BIT] = st.ptw_cap;
        rd_mux[lsl_pkg::STAT_ONTIME_BIT] = st.ontime_ok;
      end
      lsl_pkg::OFS_LIVE:
      begin
        rd_mux[N-1:0] = sink_q;
        rd_mux[lsl_pkg::LIVE_BLANK_BIT] = blank_lvl;
        rd_mux[lsl_pkg::LIVE_PTW_BIT] = ptw_lvl;
      end
      lsl_pkg::OFS_IRQ_STAT:
        rd_mux[lsl_pkg::IRQ_W-1:0] = irq_stat_q;
      lsl_pkg::OFS_IRQ_MASK:
        rd_mux[lsl_pkg::IRQ_W-1:0] = irq_mask_q;
      default:
        rd_mux = 32'h00000000;
    endcase
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h00000000;
      rresp_q <= lsl_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_mux;
      rresp_q <= lsl_pkg::reg_known(s_axi_araddr) ? lsl_pkg::RESP_OKAY : lsl_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      rvalid_q <= 1'b0;
  end

  assign s_axi_rvalid = rvalid_q;
  assign s_axi_rdata = rdata_q;
  assign s_axi_rresp = rresp_q;

  // Shift clock level is only used through its edge; kept for symmetry of the synchronisers
  logic unused_lvl;
  assign unused_lvl = sclk_lvl ^ lat_lvl;

endmodule : lsl_top
